// file: adcsrf_top.sv
`timescale 1ns/100ps
`default_nettype none
module adcsrf_top (
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     nrst,
    // serial pins
    input  wire logic                     csN,
    input  wire logic                     sclk,
    input  wire logic                     serialDataIn,
    output logic                          serialDataOut,
    output logic                          serialDataOutOe,
    output logic                          outputReadyN,
    // power down pin and state
    input  wire logic                     hwPowerDown,
    output logic                          powerDownActive,
    // conversion core side
    input  wire logic                     resultLoad,
    input  wire adcsrf_pkg::adcsrf_res_t  result,
    input  wire logic                     convBusy,
    input  wire logic                     calBusy,
    output logic                          convAbort,
    // output format
    input  wire adcsrf_pkg::adcsrf_fmt_t  fmt,
    // status
    output logic                          frameActive,
    output logic                          dataValid,
    output logic                          resultInvalid,
    output logic [adcsrf_pkg::RX_W-1:0]   rxWord,
    output logic                          rxStrobe
);
    import adcsrf_pkg::*;

    // latency budget: a pin edge reaches the shifter three clock
    // edges after the pin moves (two sync flops and the shifter flops themselves),
    // and the registered outputs change on that same edge; with a serial
    // clock half period of at least three clocks no edge is lost

    // ************************************************
    // pin synchronisation and edge detection
    // ************************************************
    adcsrf_pins_t pinsRaw;
    adcsrf_pins_t pinsSync;
    adcsrf_pins_t pinsPrev_q;
    logic [$bits(adcsrf_pins_t)-1:0] pinsSyncBits;

    assign pinsRaw = '{csN: csN, sclk: sclk, din: serialDataIn,
                       pd: hwPowerDown};

    // every pin passes two flops before logic sees it
    // the flops reset to the idle pin levels, so leaving reset never
    // looks like a select edge or a serial clock edge
    adcsrf_sync #(
        .W       ($bits(adcsrf_pins_t)),
        .RST_VAL (PINS_IDLE)
    ) uSync (
        .mclk    (mclk),
        .nrst    (nrst),
        .asyncIn (pinsRaw),
        .syncOut (pinsSyncBits)
    );
    assign pinsSync = adcsrf_pins_t'(pinsSyncBits);

    // previous sample, reset to deselected and idle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pinsPrev_q <= PINS_IDLE;
        end else begin
            pinsPrev_q <= pinsSync;
        end
    end

    logic csFall;
    logic csRise;
    logic sclkRise;
    logic sclkFall;
    logic pdRise;
    logic selected;

    // edges taken from second stage against its own history
    // an edge lasts exactly one cycle, so each one is acted on once
    assign csFall   = pinsPrev_q.csN & ~pinsSync.csN;
    assign csRise   = ~pinsPrev_q.csN & pinsSync.csN;
    assign sclkRise = ~pinsPrev_q.sclk & pinsSync.sclk;
    assign sclkFall = pinsPrev_q.sclk & ~pinsSync.sclk;
    assign pdRise   = ~pinsPrev_q.pd & pinsSync.pd;
    assign selected = ~pinsSync.csN;

    // ************************************************
    // result holding register
    // ************************************************
    adcsrf_res_t res_q;
    adcsrf_res_t res_d;
    logic        bad_q;
    logic        bad_d;
    logic        abort_q;
    logic        abort_d;
    logic        pdAct_q;
    logic        pdAct_d;

    // the result is held here so a frame can be read long after the
    // core has moved on; the invalid mark travels with it until the
    // next load replaces the pattern
    // power-down is taken whatever the link or core is doing
    // the power-down copy is only a status echo; the core does the rest
    always_comb begin
        res_d   = res_q;
        bad_d   = bad_q;
        abort_d = 1'h0;
        pdAct_d = pinsSync.pd;
        if (resultLoad) begin
            res_d = result;
            bad_d = 1'h0;
        end
        // abort wins over a load in the same cycle
        if (pdRise && convBusy) begin
            res_d   = '{sign: BAD_SIGN, mag: BAD_MAG};
            bad_d   = 1'h1;
            abort_d = 1'h1;
        end
    end

    // result state registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            res_q   <= '0;
            bad_q   <= 1'h0;
            abort_q <= 1'h0;
            pdAct_q <= 1'h0;
        end else begin
            res_q   <= res_d;
            bad_q   <= bad_d;
            abort_q <= abort_d;
            pdAct_q <= pdAct_d;
        end
    end

    // ************************************************
    // frame formatting
    // ************************************************
    logic [FRAME_W-1:0] seq;
    logic [CNT_W-1:0]   frameLen;

    // the formatter is pure logic; its output is only looked at on the
    // select edge, so a changing result cannot tear a frame
    adcsrf_formatter uFmt (
        .res      (res_q),
        .fmt      (fmt),
        .seq      (seq),
        .frameLen (frameLen)
    );

    // ************************************************
    // output shifter and select handling
    // ************************************************
    adcsrf_state_t      state_q;
    adcsrf_state_t      state_d;
    logic [FRAME_W-1:0] shift_q;
    logic [FRAME_W-1:0] shift_d;
    logic [CNT_W-1:0]   left_q;
    logic [CNT_W-1:0]   left_d;
    logic               oe_q;
    logic               oe_d;
    logic               rdyN_q;
    logic               rdyN_d;
    logic               valid_q;
    logic               valid_d;

    // format is snapshotted at select, so a mid-frame change is
    // not seen until the next frame
    // once the last bit has gone the shifter keeps clocking zeros out;
    // the host decides how many bits to read, so extra clocks are harmless
    // a select edge always wins over a serial clock edge in one cycle
    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        left_d  = left_q;
        oe_d    = oe_q;
        rdyN_d  = rdyN_q;
        valid_d = valid_q;
        unique case (state_q)
            ST_IDLE: begin
                if (csFall) begin
                    state_d = ST_SHIFT;
                    shift_d = seq;
                    left_d  = frameLen;
                    oe_d    = 1'h1;
                    rdyN_d  = 1'h0;
                    valid_d = ~bad_q & ~calBusy;
                end
            end
            ST_SHIFT, ST_DRAIN: begin
                if (csRise) begin
                    state_d = ST_IDLE;
                    oe_d    = 1'h0;
                    rdyN_d  = 1'h1;
                end else if (sclkFall) begin
                    shift_d = {shift_q[FRAME_W-2:0], 1'h0};
                    rdyN_d  = 1'h1;
                    if (left_q > CNT_W'(1)) begin
                        left_d = left_q - CNT_W'(1);
                    end else begin
                        left_d  = '0;
                        state_d = ST_DRAIN;
                    end
                end
                // a calibration cycle spoils the whole frame
                if (calBusy) begin
                    valid_d = 1'h0;
                end
            end
            // an illegal state code falls back to idle with the line released
            default: begin
                state_d = ST_IDLE;
                oe_d    = 1'h0;
                rdyN_d  = 1'h1;
            end
        endcase
    end

    // shifter state registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            shift_q <= '0;
            left_q  <= '0;
            oe_q    <= 1'h0;
            rdyN_q  <= 1'h1;
            valid_q <= 1'h0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            left_q  <= left_d;
            oe_q    <= oe_d;
            rdyN_q  <= rdyN_d;
            valid_q <= valid_d;
        end
    end

    // ************************************************
    // serial input capture
    // ************************************************
    logic [RX_W-1:0] rxShift_q;
    logic [RX_W-1:0] rxShift_d;
    logic [2:0]      rxCnt_q;
    logic [2:0]      rxCnt_d;
    logic [RX_W-1:0] rxWord_q;
    logic [RX_W-1:0] rxWord_d;
    logic            rxStb_q;
    logic            rxStb_d;

    // a partial byte is dropped when select goes away
    // bytes are counted from the select edge; the count only wraps, so a
    // long frame yields one strobe per full byte
    always_comb begin
        rxShift_d = rxShift_q;
        rxCnt_d   = rxCnt_q;
        rxWord_d  = rxWord_q;
        rxStb_d   = 1'h0;
        if (!selected) begin
            rxCnt_d = '0;
        end else if (sclkRise) begin
            rxShift_d = {rxShift_q[RX_W-2:0], pinsSync.din};
            rxCnt_d   = rxCnt_q + 3'h1;
            if (rxCnt_q == RX_LAST) begin
                rxWord_d = {rxShift_q[RX_W-2:0], pinsSync.din};
                rxStb_d  = 1'h1;
            end
        end
    end

    // capture state registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rxShift_q <= '0;
            rxCnt_q   <= '0;
            rxWord_q  <= '0;
            rxStb_q   <= 1'h0;
        end else begin
            rxShift_q <= rxShift_d;
            rxCnt_q   <= rxCnt_d;
            rxWord_q  <= rxWord_d;
            rxStb_q   <= rxStb_d;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    // status outputs are straight copies of registers so the far side
    // never sees a combinational glitch, at the cost of one cycle of
    // latency on each of them
    // data line keeps the shifter top bit while released, the bench sees oe low
    assign serialDataOut   = shift_q[FRAME_W-1];
    assign serialDataOutOe = oe_q;
    assign outputReadyN    = rdyN_q;
    assign powerDownActive = pdAct_q;
    assign convAbort       = abort_q;
    assign frameActive     = oe_q;
    assign dataValid       = valid_q;
    assign resultInvalid   = bad_q;
    assign rxWord          = rxWord_q;
    assign rxStrobe        = rxStb_q;
endmodule : adcsrf_top
`default_nettype wire

// file: adcsrf_pkg.sv
`default_nettype none
package adcsrf_pkg;

    // ************************************************
    // widths
    // ************************************************
    localparam int          RES_W   = 12;
    localparam int          SHORT_W = 8;
    localparam int          FRAME_W = 17;
    localparam int          CNT_W   = 5;
    localparam int          RX_W    = 8;

    // ************************************************
    // frame lengths and fill values
    // ************************************************
    localparam logic [4:0]  LEN_8      = 5'h08;
    localparam logic [4:0]  LEN_12     = 5'h0C;
    localparam logic [4:0]  LEN_16     = 5'h10;
    localparam logic [4:0]  FRAME_LEN  = 5'h11;
    localparam logic [3:0]  DATA_SHORT = 4'h8;
    localparam logic [3:0]  DATA_FULL  = 4'hC;
    localparam logic [11:0] BAD_MAG    = 12'hFFF;
    localparam logic        BAD_SIGN   = 1'h1;
    localparam logic [2:0]  RX_LAST    = 3'h7;

    // word length selector; code 3 is illegal and acts as 12
    typedef enum logic [1:0] {
        LEN_SHORT = 2'h0,
        LEN_MID   = 2'h1,
        LEN_LONG  = 2'h2
    } adcsrf_len_t;

    typedef struct packed {
        logic        signedOut;
        logic        msbFirst;
        adcsrf_len_t len;
    } adcsrf_fmt_t;

    typedef struct packed {
        logic        sign;
        logic [11:0] mag;
    } adcsrf_res_t;

    typedef struct packed {
        logic csN;
        logic sclk;
        logic din;
        logic pd;
    } adcsrf_pins_t;

    // pin levels while deselected and idle; also the sync reset value
    localparam adcsrf_pins_t PINS_IDLE = '{csN: 1'h1, sclk: 1'h0,
                                           din: 1'h0, pd: 1'h0};

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_SHIFT = 3'h2,
        ST_DRAIN = 3'h4
    } adcsrf_state_t;

endpackage : adcsrf_pkg
`default_nettype wire

// file: adcsrf_sync.sv
`timescale 1ns/100ps
`default_nettype none
module adcsrf_sync #(
    parameter int           W       = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         nrst,
    // asynchronous levels in, synchronised out
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage is read only by the second; both reset to the idle
    // levels so leaving reset never looks like a pin edge
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
        end
    end

    assign syncOut = sync_q;
endmodule : adcsrf_sync
`default_nettype wire

// file: adcsrf_formatter.sv
`timescale 1ns/100ps
`default_nettype none
module adcsrf_formatter (
    // result and format in
    input  wire adcsrf_pkg::adcsrf_res_t     res,
    input  wire adcsrf_pkg::adcsrf_fmt_t     fmt,
    // left-aligned frame, top bit goes out first
    output logic [adcsrf_pkg::FRAME_W-1:0]   seq,
    output logic [adcsrf_pkg::CNT_W-1:0]     frameLen
);
    import adcsrf_pkg::*;

    // reverse the low n bits; bits above n stay zero
    function automatic logic [FRAME_W-1:0] revLow(
        input logic [FRAME_W-1:0] c,
        input logic [CNT_W-1:0]   n
    );
        logic [FRAME_W-1:0] r;
        r = '0;
        for (int i = 0; i < FRAME_W; i++) begin
            if (i < int'(n)) begin
                r[i] = c[int'(n) - 1 - i];
            end
        end
        return r;
    endfunction : revLow

    logic [FRAME_W-1:0] core;
    logic [CNT_W-1:0]   n;
    logic [3:0]         dataW;

    // build in MSB-first order, right aligned; fill bits are zero
    always_comb begin
        core  = '0;
        n     = LEN_12;
        dataW = DATA_FULL;
        unique case (fmt.len)
            LEN_SHORT: begin
                core  = FRAME_W'(res.mag[RES_W-1 -: SHORT_W]);
                n     = LEN_8;
                dataW = DATA_SHORT;
            end
            LEN_LONG: begin
                core = FRAME_W'(res.mag); // zero pad above
                n    = LEN_16;
            end
            default: begin
                core = FRAME_W'(res.mag);
                n    = LEN_12;
            end
        endcase
        // sign sits just above the data, below any fill
        if (fmt.signedOut) begin
            core = core | (FRAME_W'(res.sign) << dataW);
            n    = n + CNT_W'(1);
        end
        // LSB-first is the exact mirror of MSB-first
        if (!fmt.msbFirst) begin
            core = revLow(core, n);
        end
        seq      = core << (FRAME_LEN - n);
        frameLen = n;
    end
endmodule : adcsrf_formatter
`default_nettype wire

// file: adcsrf_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module adcsrf_top_assertions (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // serial pins
    input wire logic csN,
    input wire logic sclk,
    input wire logic serialDataOut,
    input wire logic serialDataOutOe,
    input wire logic outputReadyN,
    // power down and core side
    input wire logic hwPowerDown,
    input wire logic powerDownActive,
    input wire logic convBusy,
    input wire logic calBusy,
    input wire logic convAbort,
    // status
    input wire logic frameActive,
    input wire logic dataValid,
    input wire logic resultInvalid
);
    // *******************
    // checks
    // *******************
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    // pin edges take two sync flops plus an edge compare
    ready_low_a: assert property ($fell(csN) |-> ##[3:4]
        (!outputReadyN && serialDataOutOe)) else $error("ready not low");
    ready_high_a: assert property ($fell(sclk) && !csN |-> ##[3:4]
        outputReadyN) else $error("ready not back high");
    release_out_a: assert property ($rose(csN) |-> ##[3:4]
        !serialDataOutOe) else $error("output not released");
    // a rise never moves the data line, only a fall does
    bit_hold_a: assert property ($rose(sclk) && !csN |=>
        $stable(serialDataOut)[*4]) else $error("data moved after rise");
    pd_follow_a: assert property ($rose(hwPowerDown) |-> ##[2:4]
        powerDownActive) else $error("power down not seen");
    abort_pulse_a: assert property ($rose(hwPowerDown) && convBusy
        |-> ##[2:3] convAbort) else $error("no abort pulse");
    abort_once_a: assert property (convAbort |=> !convAbort)
        else $error("abort longer than one cycle");
    abort_mark_a: assert property (convAbort |-> resultInvalid)
        else $error("abort without invalid mark");
    cal_void_a: assert property (calBusy && frameActive |=> !dataValid)
        else $error("valid during calibration");

    cover property ($fell(csN));
    cover property (convAbort);
    cover property (calBusy && frameActive);
endmodule : adcsrf_top_assertions
`default_nettype wire

// file: adcsrf_host.sv
`timescale 1ns/100ps
`default_nettype none
module adcsrf_host (
    // serial pins towards the device
    output var logic csN,
    output var logic sclk,
    output var logic serialDataIn,
    input wire logic serialDataOut,
    input wire logic serialDataOutOe
);
    // *******************
    // host side of the link
    // *******************
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        serialDataIn = 1'b0;
    end

    // no status reads are issued, so no narrow conversion precedes one
    // one bit per 80 ns period; rx is left aligned, first bit on top
    task automatic xfer(input int n, input logic [16:0] tx,
                        output logic [16:0] rx);
        rx = '0;
        csN = 1'b0; // clock already rests low after its last fall
        serialDataIn = tx[16];
        #56;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b1; // device takes the input on this rise
            #40;
            rx[16-i] = serialDataOutOe ? serialDataOut : ~serialDataOut;
            sclk = 1'b0;
            if (i < 16) serialDataIn = tx[15-i]; // away from the rise
            #40;
        end
        csN = 1'b1;
        // a released line must not keep showing the last level
        serialDataIn = ~serialDataIn;
    endtask : xfer
endmodule : adcsrf_host
`default_nettype wire

// file: adcsrf_bench.sv
`timescale 1ns/100ps
`default_nettype none
module adcsrf_bench;
    import adcsrf_pkg::*;
    // *******************
    // signals
    // *******************
    logic            mclk = 1'b0;
    logic            nrst = 1'b0;
    logic            csN, sclk, serialDataIn, serialDataOut, serialDataOutOe;
    logic            outputReadyN, hwPowerDown, powerDownActive, resultLoad;
    logic            convBusy, calBusy, convAbort, frameActive, dataValid;
    logic            resultInvalid, rxStrobe;
    logic [RX_W-1:0] rxWord;
    adcsrf_res_t     result;
    adcsrf_res_t     stored;
    adcsrf_fmt_t     fmt;
    int              miscompares = 0;
    int              n_tests = 0;
    int              strobes = 0;

    always #4 mclk = ~mclk;

    // every byte strobe the design raises, counted per frame
    always @(posedge mclk) begin
        if (rxStrobe === 1'b1) strobes++;
    end

    adcsrf_top i_dut (.mclk(mclk), .nrst(nrst), .csN(csN), .sclk(sclk),
        .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
        .serialDataOutOe(serialDataOutOe), .outputReadyN(outputReadyN),
        .hwPowerDown(hwPowerDown), .powerDownActive(powerDownActive),
        .resultLoad(resultLoad), .result(result), .convBusy(convBusy),
        .calBusy(calBusy), .convAbort(convAbort), .fmt(fmt),
        .frameActive(frameActive), .dataValid(dataValid),
        .resultInvalid(resultInvalid), .rxWord(rxWord), .rxStrobe(rxStrobe));

    adcsrf_host i_host (.csN(csN), .sclk(sclk), .serialDataIn(serialDataIn),
        .serialDataOut(serialDataOut), .serialDataOutOe(serialDataOutOe));

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [16:0] exp,
                         input logic [16:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // keeps every input change one ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    // frame as the host should see it, fill first then sign then magnitude
    function automatic void model(input adcsrf_res_t r, input adcsrf_fmt_t f,
                                  output logic [16:0] s, output int n);
        int q[$];
        if (f.len == LEN_LONG) repeat (4) q.push_back(0);
        if (f.signedOut) q.push_back(r.sign);
        for (int k = 11; k >= (f.len == LEN_SHORT ? 4 : 0); k--)
            q.push_back(r.mag[k]);
        if (!f.msbFirst) q.reverse(); // lsb-first is the exact mirror
        n = q.size();
        s = '0;
        foreach (q[i]) s[16-i] = q[i];
    endfunction : model

    task automatic load(input adcsrf_res_t r);
        result = r;
        stored = r;
        resultLoad = 1'b1;
        tick(1);
        resultLoad = 1'b0;
        tick(1);
    endtask : load

    task automatic frame(input logic dv);
        logic [16:0] s, got, tx;
        int n;
        tx = 17'($urandom);
        model(stored, fmt, s, n);
        strobes = 0;
        i_host.xfer(n, tx, got);
        tick(6);
        check("frame bits", s, got & ~(17'h1FFFF >> n));
        check("drive after deselect", 0, serialDataOutOe);
        check("data valid", dv, dataValid);
        check("captured word", tx[16-8*(n/8-1) -: 8], rxWord);
        check("byte strobes", n / 8, strobes);
    endtask : frame

    // *******************
    // tests
    // *******************
    initial begin
        int w;
        hwPowerDown = 1'b0;
        resultLoad = 1'b0;
        result = '0;
        stored = '0;
        convBusy = 1'b0;
        calBusy = 1'b0;
        fmt = '0;
        void'($urandom(4));
        repeat (6) @(posedge mclk);
        #1;
        nrst = 1'b1;
        tick(4);
        for (int c = 0; c < 16; c++) begin
            fmt = adcsrf_fmt_t'(4'(c));
            load(adcsrf_res_t'(13'($urandom)));
            frame(1'b1);
        end
        $display("test formats done");
        calBusy = 1'b1;
        frame(1'b0);
        calBusy = 1'b0;
        $display("test calibration done");
        convBusy = 1'b1;
        hwPowerDown = 1'b1;
        for (w = 0; w < 10 && convAbort !== 1'b1; w++) tick(1);
        if (convAbort !== 1'b1) begin
            $display("Error abort pulse expected 1 seen %b", convAbort);
            miscompares++;
            give_verdict();
        end
        check("invalid flag", 1, resultInvalid);
        check("power down seen", 1, powerDownActive);
        stored = {BAD_SIGN, BAD_MAG};
        tick(1);
        convBusy = 1'b0;
        hwPowerDown = 1'b0;
        tick(6);
        fmt = adcsrf_fmt_t'(4'hE);
        frame(1'b0);
        load(adcsrf_res_t'(13'($urandom)));
        check("invalid cleared", 0, resultInvalid);
        frame(1'b1);
        $display("test power down done");
        give_verdict();
    end

    initial begin
        #700000;
        $display("Error run time expected finished seen still running");
        miscompares++;
        give_verdict();
    end
endmodule : adcsrf_bench

bind adcsrf_top adcsrf_top_assertions i_chk (.mclk(mclk), .nrst(nrst),
    .csN(csN), .sclk(sclk), .serialDataOut(serialDataOut),
    .serialDataOutOe(serialDataOutOe), .outputReadyN(outputReadyN),
    .hwPowerDown(hwPowerDown), .powerDownActive(powerDownActive),
    .convBusy(convBusy), .calBusy(calBusy), .convAbort(convAbort),
    .frameActive(frameActive), .dataValid(dataValid),
    .resultInvalid(resultInvalid));
`default_nettype wire
